// File: shared/sasp_pkg.sv
package sasp_pkg;

   // Register addresses on the peripheral bus
   localparam logic [15:0] SASP_ADDR_DATA  = 16'h3810;
   localparam logic [15:0] SASP_ADDR_STAT2 = 16'h3811;
   localparam logic [15:0] SASP_ADDR_SET   = 16'h3812;

   localparam int          SASP_WORD_W     = 16;
   localparam logic [15:0] SASP_SET_RESET  = 16'h8012;
   localparam logic [15:0] SASP_ZERO_WORD  = 16'h0000;

   // Setting register field positions
   localparam int SASP_B_IFSEL  = 15;
   localparam int SASP_B_OUT_EN = 14;
   localparam int SASP_B_IN_EN  = 13;
   localparam int SASP_B_DIV_HI = 12;
   localparam int SASP_B_DIV_LO = 10;
   localparam int SASP_B_ARST   = 9;
   localparam int SASP_B_SWAIT  = 8;
   localparam int SASP_B_LWAIT  = 7;
   localparam int SASP_B_OLEN   = 6;
   localparam int SASP_B_ILEN   = 5;
   localparam int SASP_B_SLAVE  = 4;
   localparam int SASP_B_SERR   = 3;
   localparam int SASP_B_LERR   = 2;
   localparam int SASP_B_SEN    = 1;
   localparam int SASP_B_LEN    = 0;

   // Frame lengths in bits and 16-bit accesses per frame
   localparam logic [6:0] SASP_FRAME_LONG  = 7'h40;
   localparam logic [6:0] SASP_FRAME_SHORT = 7'h20;
   localparam logic [6:0] SASP_CNT_ONE     = 7'h01;
   localparam logic [1:0] SASP_LAST_LONG   = 2'h3;
   localparam logic [1:0] SASP_LAST_SHORT  = 2'h1;
   localparam logic [1:0] SASP_SHORT_BASE  = 2'h2;

   // Master clock divider selections
   localparam logic [2:0] SASP_DIV_4_256  = 3'h0;
   localparam logic [2:0] SASP_DIV_8_256  = 3'h1;
   localparam logic [2:0] SASP_DIV_6_384  = 3'h2;
   localparam logic [2:0] SASP_DIV_12_384 = 3'h3;
   localparam logic [2:0] SASP_DIV_8_512  = 3'h4;
   localparam logic [2:0] SASP_DIV_16_512 = 3'h5;

   // Half bit-clock period in master clock rising edges
   function automatic logic [3:0] sasp_bclk_half(input logic [2:0] sel);
      case (sel)
         SASP_DIV_8_256:  sasp_bclk_half = 4'h4;
         SASP_DIV_6_384:  sasp_bclk_half = 4'h3;
         SASP_DIV_12_384: sasp_bclk_half = 4'h6;
         SASP_DIV_8_512:  sasp_bclk_half = 4'h4;
         SASP_DIV_16_512: sasp_bclk_half = 4'h8;
         default:         sasp_bclk_half = 4'h2;
      endcase
   endfunction : sasp_bclk_half

   // Half frame-clock period in bit-clock periods
   function automatic logic [5:0] sasp_lr_half(input logic [2:0] sel);
      case (sel)
         SASP_DIV_8_256, SASP_DIV_12_384, SASP_DIV_16_512: sasp_lr_half = 6'h10;
         default:                                          sasp_lr_half = 6'h20;
      endcase
   endfunction : sasp_lr_half

endpackage : sasp_pkg

// File: src/sasp_clk_div.sv
// Master-mode clock maker: bit clock and frame clock from the sampled master clock
module sasp_clk_div
   import sasp_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic       enable,
   input  wire logic       mclk_pin,
   input  wire logic [2:0] div_sel,
   output logic            bclk_q,
   output logic            lrclk_q
);

   logic       mclk_prev_q, mclk_prev_d;
   logic [3:0] mcnt_q, mcnt_d;
   logic [5:0] lcnt_q, lcnt_d;
   logic       bclk_d, lrclk_d;

   // Count master clock rising edges; frame clock toggles on bit clock falls
   always_comb begin
      mclk_prev_d = mclk_pin;
      mcnt_d      = mcnt_q;
      lcnt_d      = lcnt_q;
      bclk_d      = bclk_q;
      lrclk_d     = lrclk_q;
      if (!enable) begin                       // Slave mode: master clock ignored
         mcnt_d  = '0;
         lcnt_d  = '0;
         bclk_d  = 1'b0;
         lrclk_d = 1'b0;
      end else if (mclk_pin && !mclk_prev_q) begin
         if (mcnt_q == sasp_bclk_half(div_sel) - 4'h1) begin
            mcnt_d = '0;
            bclk_d = !bclk_q;
            if (bclk_q) begin                  // Falling bit clock edge
               if (lcnt_q == sasp_lr_half(div_sel) - 6'h01) begin
                  lcnt_d  = '0;
                  lrclk_d = !lrclk_q;
               end else begin
                  lcnt_d = lcnt_q + 6'h01;
               end
            end
         end else begin
            mcnt_d = mcnt_q + 4'h1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         mclk_prev_q <= 1'b0;
         mcnt_q      <= '0;
         lcnt_q      <= '0;
         bclk_q      <= 1'b0;
         lrclk_q     <= 1'b0;
      end else begin
         mclk_prev_q <= mclk_prev_d;
         mcnt_q      <= mcnt_d;
         lcnt_q      <= lcnt_d;
         bclk_q      <= bclk_d;
         lrclk_q     <= lrclk_d;
      end
   end

endmodule : sasp_clk_div

// File: src/sasp_audio_port.sv
// Functional notes
// - Master drives bit and frame clocks from master clock; slave takes them in.
// - After reset the bit clock pin is an input (slave mode).
// - Slave uses incoming bit clock directly; master divides the master clock.
// - Frame length 32 or 64 bits, chosen separately for input and output.
// - One frame clock period spans 32 or 64 bit clock cycles.
// - Serial input is sampled on each rising bit clock edge.
// - Serial output changes only on falling bit clock edges.
// - Core handshake by polling flags, bus wait states, or request outputs.
// - Data register store writes the 64-bit output holding register.
// - Empty output shifter reloads from output holding register, sent MSB first.
// - Store while store enable is 0 sets the store error flag.
// - After the fourth or second store, the store enable flag clears.
// - After a frame's last bit, input shifter is copied to input holding register.
// - Load while load enable is 0 sets the load error flag.
// - After the fourth or second load, the load enable flag clears.
// - Three-bit divider selects 4/256 to 16/512 master clock division; default 4/256.
// - Store enable sets when holding data moves to the shifter; 1 after reset.
// - Error flags stay 1 until the core writes 0 to them or requests a port reset.
// - Per-direction length bit: 0 means 64 bits (default), 1 means 32 bits.
module sasp_audio_port
   import sasp_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic [15:0] bus_addr,
   input  wire logic        bus_wr,
   input  wire logic        bus_rd,
   input  wire logic [15:0] bus_wdata,
   output logic      [15:0] bus_rdata_q,
   output logic             bus_ack_q,
   output logic             bus_wait_q,
   output logic             out_req_q,
   output logic             in_req_q,
   input  wire logic        mclk_pin,
   input  wire logic        bclk_in,
   output logic             bclk_out_q,
   output logic             bclk_oe_n_q,
   input  wire logic        lrclk_in,
   output logic             lrclk_out_q,
   output logic             lrclk_oe_n_q,
   input  wire logic        serial_in_pin,
   output logic             serial_out_pin_q
);

   // Setting register bits 15..4 (bit 9 never held), flags and counters
   logic [15:4] set_q, set_d;
   logic        serr_q, serr_d, lerr_q, lerr_d, sen_q, sen_d, len_q, len_d;
   logic [15:0] stat2_q, stat2_d;
   logic [63:0] hold_out_q, hold_out_d, hold_in_q, hold_in_d;
   logic [63:0] tx_sr_q, tx_sr_d, rx_sr_q, rx_sr_d;
   logic [6:0]  rx_cnt_q, rx_cnt_d;
   logic        rx_sync_q, rx_sync_d;
   logic [1:0]  wr_cnt_q, wr_cnt_d, rd_cnt_q, rd_cnt_d;
   logic        bclk_prev_q, lr_rise_q, lr_rise_d, lr_fall_q, lr_fall_d;
   logic        serial_out_d, bus_ack_d, bus_wait_d, bclk_oe_n_d;
   logic [15:0] bus_rdata_d;
   logic        div_bclk, div_lrclk;

   logic        slave, olen32, ilen32, bclk_s, lrclk_s, bclk_rise, bclk_fall;
   logic        take, stall, go, is_data, is_set, is_stat2;
   logic        tx_load, rx_done, arst;
   logic [1:0]  wr_pos, rd_pos;
   logic [63:0] rx_shift;
   logic [6:0]  rx_next;

   assign slave  = set_q[SASP_B_SLAVE];
   assign olen32 = set_q[SASP_B_OLEN];
   assign ilen32 = set_q[SASP_B_ILEN];

   // Clock source: own divider in master mode, the pins in slave mode
   sasp_clk_div u_clk_div (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .enable  (!slave),
      .mclk_pin(mclk_pin),
      .div_sel (set_q[SASP_B_DIV_HI:SASP_B_DIV_LO]),
      .bclk_q  (div_bclk),
      .lrclk_q (div_lrclk)
   );

   assign bclk_s    = slave ? bclk_in : div_bclk;
   assign lrclk_s   = slave ? lrclk_in : div_lrclk;
   assign bclk_rise = bclk_s && !bclk_prev_q;
   assign bclk_fall = !bclk_s && bclk_prev_q;

   // Frame boundary is the falling frame clock; output reloads there
   assign tx_load = bclk_fall && !lrclk_s && lr_fall_q;
   assign rx_shift = {rx_sr_q[62:0], serial_in_pin};
   assign rx_next  = (!lrclk_s && lr_rise_q) ? SASP_CNT_ONE : rx_cnt_q + SASP_CNT_ONE;
   assign rx_done  = bclk_rise && set_q[SASP_B_IN_EN] && (rx_sync_q || (!lrclk_s && lr_rise_q))
                     && (rx_next == (ilen32 ? SASP_FRAME_SHORT : SASP_FRAME_LONG));

   // Bus decode; a held request is taken once, then acknowledged
   assign is_data  = (bus_addr == SASP_ADDR_DATA);
   assign is_stat2 = (bus_addr == SASP_ADDR_STAT2);
   assign is_set   = (bus_addr == SASP_ADDR_SET);
   assign take     = (bus_wr || bus_rd) && !bus_ack_q;
   assign stall    = is_data && ((bus_wr && !sen_q && set_q[SASP_B_SWAIT])
                              || (bus_rd && !bus_wr && !len_q && set_q[SASP_B_LWAIT]));
   assign go       = take && !stall;
   assign arst     = go && bus_wr && is_set && bus_wdata[SASP_B_ARST];
   assign wr_pos   = olen32 ? wr_cnt_q + SASP_SHORT_BASE : wr_cnt_q;
   assign rd_pos   = ilen32 ? rd_cnt_q + SASP_SHORT_BASE : rd_cnt_q;

   // Next state: bus actions, then serial events so a set wins over a clear, port reset last
   always_comb begin
      set_d        = set_q;
      serr_d       = serr_q;
      lerr_d       = lerr_q;
      sen_d        = sen_q;
      len_d        = len_q;
      stat2_d      = stat2_q;
      hold_out_d   = hold_out_q;
      hold_in_d    = hold_in_q;
      tx_sr_d      = tx_sr_q;
      rx_sr_d      = rx_sr_q;
      rx_cnt_d     = rx_cnt_q;
      rx_sync_d    = rx_sync_q;
      wr_cnt_d     = wr_cnt_q;
      rd_cnt_d     = rd_cnt_q;
      lr_rise_d    = bclk_rise ? lrclk_s : lr_rise_q;
      lr_fall_d    = bclk_fall ? lrclk_s : lr_fall_q;
      serial_out_d = serial_out_pin_q;
      bus_ack_d    = go;
      bus_wait_d   = take && stall;
      bus_rdata_d  = bus_rdata_q;
      bclk_oe_n_d  = slave;
      if (go && bus_wr) begin
         if (is_set) begin
            set_d = bus_wdata[15:4];
            set_d[SASP_B_ARST] = 1'b0;                            // Request bit reads back 0
            if (!bus_wdata[SASP_B_SERR]) serr_d = 1'b0;
            if (!bus_wdata[SASP_B_LERR]) lerr_d = 1'b0;
         end else if (is_stat2) begin
            stat2_d = bus_wdata;
         end else if (is_data) begin
            if (sen_q) begin
               hold_out_d[SASP_WORD_W*(3-int'(wr_pos)) +: SASP_WORD_W] = bus_wdata;
               if (wr_cnt_q == (olen32 ? SASP_LAST_SHORT : SASP_LAST_LONG)) begin
                  wr_cnt_d = '0;
                  sen_d    = 1'b0;
               end else begin
                  wr_cnt_d = wr_cnt_q + 2'h1;
               end
            end else begin
               serr_d = 1'b1;
            end
         end
      end else if (go && bus_rd) begin
         if (is_set) begin
            bus_rdata_d = {set_q, serr_q, lerr_q, sen_q, len_q};
         end else if (is_stat2) begin
            bus_rdata_d = stat2_q;
         end else if (is_data) begin
            bus_rdata_d = hold_in_q[SASP_WORD_W*(3-int'(rd_pos)) +: SASP_WORD_W];
            if (len_q) begin
               if (rd_cnt_q == (ilen32 ? SASP_LAST_SHORT : SASP_LAST_LONG)) begin
                  rd_cnt_d = '0;
                  len_d    = 1'b0;
               end else begin
                  rd_cnt_d = rd_cnt_q + 2'h1;
               end
            end else begin
               lerr_d = 1'b1;
            end
         end else begin
            bus_rdata_d = SASP_ZERO_WORD;                         // Unmapped address reads zero
         end
      end
      // Output side changes only on falling bit clock edges
      if (bclk_fall) begin
         if (!set_q[SASP_B_OUT_EN]) begin
            serial_out_d = 1'b0;
         end else if (tx_load) begin
            tx_sr_d      = olen32 ? {hold_out_q[31:0], 32'h0} : hold_out_q;
            serial_out_d = tx_sr_d[63];
            tx_sr_d      = {tx_sr_d[62:0], 1'b0};
            sen_d        = 1'b1;
         end else begin
            serial_out_d = tx_sr_q[63];
            tx_sr_d      = {tx_sr_q[62:0], 1'b0};
         end
      end
      // Input side shifts on rising edges; whole frame copied in one cycle
      if (bclk_rise && set_q[SASP_B_IN_EN]) begin
         rx_sr_d  = rx_shift;
         rx_cnt_d = rx_next;
         if (!lrclk_s && lr_rise_q) rx_sync_d = 1'b1;
         if (rx_done) begin
            hold_in_d = ilen32 ? {32'h0, rx_shift[31:0]} : rx_shift;
            len_d     = 1'b1;
            rx_cnt_d  = '0;
         end
      end
      // Port reset request: flags and counters back to idle
      if (arst) begin
         serr_d    = 1'b0;
         lerr_d    = 1'b0;
         sen_d     = 1'b1;
         len_d     = 1'b0;
         wr_cnt_d  = '0;
         rd_cnt_d  = '0;
         rx_cnt_d  = '0;
         rx_sync_d = 1'b0;
         tx_sr_d   = '0;
      end
   end

   // Register everything; reset gives slave mode with pins as inputs
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         set_q            <= SASP_SET_RESET[15:4];
         serr_q           <= SASP_SET_RESET[SASP_B_SERR];
         lerr_q           <= SASP_SET_RESET[SASP_B_LERR];
         sen_q            <= SASP_SET_RESET[SASP_B_SEN];
         len_q            <= SASP_SET_RESET[SASP_B_LEN];
         stat2_q          <= '0;
         hold_out_q       <= '0;
         hold_in_q        <= '0;
         tx_sr_q          <= '0;
         rx_sr_q          <= '0;
         rx_cnt_q         <= '0;
         rx_sync_q        <= 1'b0;
         wr_cnt_q         <= '0;
         rd_cnt_q         <= '0;
         bclk_prev_q      <= 1'b0;
         lr_rise_q        <= 1'b0;
         lr_fall_q        <= 1'b0;
         serial_out_pin_q <= 1'b0;
         bus_ack_q        <= 1'b0;
         bus_wait_q       <= 1'b0;
         bus_rdata_q      <= '0;
         bclk_oe_n_q      <= 1'b1;
         lrclk_oe_n_q     <= 1'b1;
         bclk_out_q       <= 1'b0;
         lrclk_out_q      <= 1'b0;
         out_req_q        <= 1'b0;
         in_req_q         <= 1'b0;
      end else begin
         set_q            <= set_d;
         serr_q           <= serr_d;
         lerr_q           <= lerr_d;
         sen_q            <= sen_d;
         len_q            <= len_d;
         stat2_q          <= stat2_d;
         hold_out_q       <= hold_out_d;
         hold_in_q        <= hold_in_d;
         tx_sr_q          <= tx_sr_d;
         rx_sr_q          <= rx_sr_d;
         rx_cnt_q         <= rx_cnt_d;
         rx_sync_q        <= rx_sync_d;
         wr_cnt_q         <= wr_cnt_d;
         rd_cnt_q         <= rd_cnt_d;
         bclk_prev_q      <= bclk_s;
         lr_rise_q        <= lr_rise_d;
         lr_fall_q        <= lr_fall_d;
         serial_out_pin_q <= serial_out_d;
         bus_ack_q        <= bus_ack_d;
         bus_wait_q       <= bus_wait_d;
         bus_rdata_q      <= bus_rdata_d;
         bclk_oe_n_q      <= bclk_oe_n_d;
         lrclk_oe_n_q     <= bclk_oe_n_d;
         bclk_out_q       <= div_bclk;
         lrclk_out_q      <= div_lrclk;
         out_req_q        <= sen_d && set_q[SASP_B_OUT_EN];
         in_req_q         <= len_d && set_q[SASP_B_IN_EN];
      end
   end

   // Checks next to the logic
   a_pin_dir: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !bclk_oe_n_q |-> !$past(slave)) else $error("bit clock driven in slave mode");
   a_reset_slave: assert property (@(posedge clk_sys)
      $past(!rst_n) && rst_n |-> bclk_oe_n_q && lrclk_oe_n_q) else $error("clock pins driven after reset");
   a_div_mclk: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !slave && $changed(div_bclk) |-> $past(mclk_pin) && !$past(mclk_pin, 2))
      else $error("bit clock moved without a master clock edge");
   a_out_fall: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $changed(serial_out_pin_q) |-> $past(bclk_fall)) else $error("serial output changed off a falling edge");
   a_in_capture: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $changed(hold_in_q) && !$past(arst) |-> $past(bclk_rise) && len_q) else $error("input frame captured off edge");
   a_store_error: assert property (@(posedge clk_sys) disable iff (!rst_n)
      go && bus_wr && is_data && !sen_q |=> serr_q) else $error("store error not flagged");
   a_store_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
      go && bus_wr && is_data && sen_q && wr_cnt_q == (olen32 ? SASP_LAST_SHORT : SASP_LAST_LONG) && !tx_load
      |=> !sen_q && wr_cnt_q == 2'h0) else $error("store enable not cleared after last word");
   a_load_error: assert property (@(posedge clk_sys) disable iff (!rst_n)
      go && bus_rd && !bus_wr && is_data && !len_q |=> lerr_q) else $error("load error not flagged");
   a_load_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
      go && bus_rd && !bus_wr && is_data && len_q && !rx_done
      && rd_cnt_q == (ilen32 ? SASP_LAST_SHORT : SASP_LAST_LONG) |=> !len_q) else $error("load enable stuck");
   a_sen_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
      tx_load && set_q[SASP_B_OUT_EN] |=> sen_q ##1 1'b1) else $error("store enable not set on reload");
   a_err_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
      serr_q && !(go && bus_wr && is_set) |=> serr_q) else $error("store error dropped without a write");

endmodule : sasp_audio_port

// File: testbench/sasp_codec_model.sv
// Slave-mode codec: makes the bit and frame clocks, sends a fixed frame, captures the port's frame
module sasp_codec_model #(
   parameter logic [63:0] TX_WORD = 64'h0
) (
   input  wire logic   short_frame,
   output logic        bclk,
   output logic        lrclk,
   output logic        sdata_to_port,
   input  wire logic   sdata_from_port,
   output logic        frame_tick,
   output logic [63:0] rx_frame
);
   timeunit 1ns;
   timeprecision 1ps;

   // Half bit period of eight system clocks leaves margin for the port's edge sampling
   localparam int HALF_NS = 64;

   logic [63:0] rx_sh;
   int          flen;

   // Free-running audio clocks, frames back to back
   initial begin
      bclk = 1'b1;
      lrclk = 1'b1;
      sdata_to_port = 1'b0;
      frame_tick = 1'b0;
      rx_frame = 64'h0;
      rx_sh = 64'h0;
      forever begin
         frame_tick = ~frame_tick;
         // Length taken once per frame, so a change never cuts a frame short
         flen = (short_frame === 1'b1) ? 32 : 64;
         for (int i = 0; i < flen; i++) begin
            bclk = 1'b0;
            lrclk = (i >= flen / 2);
            sdata_to_port = TX_WORD[flen - 1 - i];
            #HALF_NS;
            bclk = 1'b1;
            rx_sh = {rx_sh[62:0], sdata_from_port};
            #HALF_NS;
         end
         rx_frame = rx_sh;
      end
   end
endmodule : sasp_codec_model

// File: testbench/tb.sv
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin miscompares++; \
   $display("wrong value %s exp %h got %h", what, exp, got); end end

module tb;
   import sasp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [63:0] OUT_WORD  = 64'h1357_9bdf_2468_ace0;
   localparam logic [63:0] IN_WORD   = 64'hc3a5_0f96_7e81_5a3c;
   localparam logic [15:0] SLAVE_ON  = 16'he010;
   localparam logic [15:0] MASTER_ON = 16'he000;
   localparam logic [15:0] SHORT_ON  = 16'he070; // Slave, 32-bit frames both ways
   localparam int          BCLK_CLKS = 16; // Master clock period is 4 system clocks, divided by 4
   localparam int          LIMIT     = 15000;

   logic        clk_sys, rst_n, bus_wr, bus_rd, mclk_pin;
   logic [15:0] bus_addr, bus_wdata, bus_rdata_q, rd_q;
   logic        bus_ack_q, bus_wait_q, out_req_q, in_req_q;
   logic        codec_bclk, codec_lr, bclk_out_q, bclk_oe_n_q, lrclk_out_q, lrclk_oe_n_q;
   logic        sdi, serial_out_pin_q, frame_tick, short_frame;
   logic [63:0] rx_frame;
   int          miscompares, compares, cycles, n;

   // Pin levels resolved from whoever drives them
   wire bclk_w = bclk_oe_n_q ? codec_bclk : bclk_out_q;
   wire lr_w   = lrclk_oe_n_q ? codec_lr : lrclk_out_q;

   sasp_audio_port dut (.clk_sys(clk_sys), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata_q(bus_rdata_q), .bus_ack_q(bus_ack_q),
      .bus_wait_q(bus_wait_q), .out_req_q(out_req_q), .in_req_q(in_req_q), .mclk_pin(mclk_pin),
      .bclk_in(bclk_w), .bclk_out_q(bclk_out_q), .bclk_oe_n_q(bclk_oe_n_q), .lrclk_in(lr_w),
      .lrclk_out_q(lrclk_out_q), .lrclk_oe_n_q(lrclk_oe_n_q), .serial_in_pin(sdi),
      .serial_out_pin_q(serial_out_pin_q));

   sasp_codec_model #(.TX_WORD(IN_WORD)) codec (.short_frame(short_frame), .bclk(codec_bclk), .lrclk(codec_lr),
      .sdata_to_port(sdi), .sdata_from_port(serial_out_pin_q), .frame_tick(frame_tick),
      .rx_frame(rx_frame));

   // Clocks; master clock offset so its edges never meet the system clock's
   initial clk_sys = 1'b0;
   always #4 clk_sys = ~clk_sys;
   initial begin
      mclk_pin = 1'b0;
      #3;
      forever #16 mclk_pin = ~mclk_pin;
   end

   task automatic close_out();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out

   // Hang guard
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         miscompares++;
         close_out();
      end
   end

   // One access, request held until the acknowledge is seen
   task automatic acc(input logic wr, input logic [15:0] addr, input logic [15:0] wd, output logic [15:0] q);
      int k;
      @(negedge clk_sys);
      bus_addr = addr;
      bus_wdata = wd;
      bus_wr = wr;
      bus_rd = ~wr;
      k = 0;
      do begin
         @(posedge clk_sys);
         #1;
         k++;
      end while (bus_ack_q !== 1'b1 && k < 1200); // A stalled store may wait a whole frame
      q = bus_rdata_q;
      `CHK("bus ack", 1'b1, bus_ack_q)
      @(negedge clk_sys);
      bus_wr = 1'b0;
      bus_rd = 1'b0;
   endtask : acc

   task automatic wr(input logic [15:0] addr, input logic [15:0] wd);
      acc(1'b1, addr, wd, rd_q);
   endtask : wr

   task automatic rd_chk(input string what, input logic [15:0] addr, input logic [15:0] mask,
                         input logic [15:0] exp);
      acc(1'b0, addr, SASP_ZERO_WORD, rd_q);
      `CHK(what, exp, rd_q & mask)
   endtask : rd_chk

   // Frame boundary plus time for the port to see the edge
   task automatic tick_wait();
      @(frame_tick);
      repeat (10) @(negedge clk_sys);
   endtask : tick_wait

   // Rise-to-rise period of a master-mode clock output, in system clocks
   task automatic period(input logic lr, output int cnt);
      cnt = 0;
      for (int ph = 0; ph < 4; ph++) begin
         do begin
            @(posedge clk_sys);
            #1;
            if (ph >= 2) cnt++;
         end while ((lr ? lrclk_out_q : bclk_out_q) !== ph[0]);
      end
   endtask : period

   initial begin
      {rst_n, bus_wr, bus_rd, bus_addr, bus_wdata, short_frame} = '0;
      {miscompares, compares, cycles} = '0;
      repeat (20) @(posedge clk_sys);
      @(negedge clk_sys);
      rst_n = 1'b1;
      rd_chk("setting reset", SASP_ADDR_SET, 16'hffff, SASP_SET_RESET);
      `CHK("bclk oe_n slave", 1'b1, bclk_oe_n_q)
      wr(SASP_ADDR_STAT2, 16'ha5c3);
      rd_chk("status two", SASP_ADDR_STAT2, 16'hffff, 16'ha5c3);
      rd_chk("unmapped", 16'h3813, 16'hffff, SASP_ZERO_WORD);
      wr(SASP_ADDR_SET, SLAVE_ON);
      tick_wait();
      for (int w = 3; w >= 0; w--) wr(SASP_ADDR_DATA, OUT_WORD[w*16 +: 16]);
      rd_chk("store enable after four", SASP_ADDR_SET, 16'h000a, 16'h0000);
      `CHK("out request low", 1'b0, out_req_q)
      wr(SASP_ADDR_DATA, 16'hffff);
      rd_chk("store error", SASP_ADDR_SET, 16'h000a, 16'h0008);
      wr(SASP_ADDR_SET, SLAVE_ON | 16'h0100);
      rd_chk("store error cleared", SASP_ADDR_SET, 16'h0008, 16'h0000);
      // Store with the enable flag low and store wait on: held off until the next reload
      @(negedge clk_sys);
      bus_addr = SASP_ADDR_DATA;
      bus_wdata = OUT_WORD[63:48];
      bus_wr = 1'b1;
      repeat (3) @(negedge clk_sys);
      `CHK("store wait", 1'b1, bus_wait_q)
      `CHK("no ack while stalled", 1'b0, bus_ack_q)
      acc(1'b1, SASP_ADDR_DATA, OUT_WORD[63:48], rd_q);
      `CHK("store wait released", 1'b0, bus_wait_q)
      rd_chk("store enable reload", SASP_ADDR_SET, 16'h0002, 16'h0002);
      `CHK("out request high", 1'b1, out_req_q)
      tick_wait();
      `CHK("serial frame", OUT_WORD, rx_frame)
      rd_chk("load enable", SASP_ADDR_SET, 16'h0001, 16'h0001);
      `CHK("in request", 1'b1, in_req_q)
      for (int w = 3; w >= 0; w--) begin
         acc(1'b0, SASP_ADDR_DATA, SASP_ZERO_WORD, rd_q);
         `CHK("load word", IN_WORD[w*16 +: 16], rd_q)
      end
      rd_chk("load enable after four", SASP_ADDR_SET, 16'h0005, 16'h0000);
      acc(1'b0, SASP_ADDR_DATA, SASP_ZERO_WORD, rd_q);
      rd_chk("load error", SASP_ADDR_SET, 16'h0004, 16'h0004);
      wr(SASP_ADDR_SET, SLAVE_ON);
      rd_chk("load error cleared", SASP_ADDR_SET, 16'h0004, 16'h0000);
      wr(SASP_ADDR_SET, SLAVE_ON | 16'h0200);
      repeat (3) @(negedge clk_sys);
      rd_chk("port reset", SASP_ADDR_SET, 16'h020f, 16'h0002);
      // 32-bit frames both ways; the codec takes the new length at its next frame
      wr(SASP_ADDR_SET, SHORT_ON);
      short_frame = 1'b1;
      wr(SASP_ADDR_DATA, IN_WORD[31:16]);
      wr(SASP_ADDR_DATA, IN_WORD[15:0]);
      rd_chk("store enable after two", SASP_ADDR_SET, 16'h000a, 16'h0000);
      tick_wait();
      tick_wait();
      `CHK("short serial frame", IN_WORD[31:0], rx_frame[31:0])
      for (int w = 1; w >= 0; w--) begin
         acc(1'b0, SASP_ADDR_DATA, SASP_ZERO_WORD, rd_q);
         `CHK("short load word", IN_WORD[w*16 +: 16], rd_q)
      end
      rd_chk("load enable after two", SASP_ADDR_SET, 16'h0005, 16'h0000);
      wr(SASP_ADDR_SET, MASTER_ON);
      period(1'b0, n);
      `CHK("bit clock period", BCLK_CLKS, n)
      period(1'b1, n);
      `CHK("frame clock period", 64 * BCLK_CLKS, n)
      `CHK("bclk oe_n master", 1'b0, bclk_oe_n_q)
      `CHK("lrclk oe_n master", 1'b0, lrclk_oe_n_q)
      close_out();
   end
endmodule : tb
